// ===== hdl/supply_charger_regs.sv
// Register bank for regulator, step-up and charger configuration.
// Assumes the serial bus front end delivers pointer/data strobes
// synchronous to sys_clk_in.
`timescale 1ns/1ps
module supply_charger_regs import chg_cfg_pkg::*; #(
    parameter int EXPIRY_CYCLES = WDOG_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] ptr_in,
    input wire logic [7:0] wdata_in,
    input wire logic charge_watchdog_on_in,
    output logic [7:0] rdata_out,
    output logic hit_out,
    output vsel_t vsel_out,
    output chg_main_t chg_main_out,
    output chg_limits_t chg_limits_out,
    output logic watchdog_expiry_flag_out
);
    // ==========================================================
    // Storage
    logic [7:0] linreg_12_voltage;
    logic [7:0] linreg_34_voltage;
    logic [7:0] step_up_voltage;
    logic [7:0] charger_setup_main;
    logic [7:0] charger_setup_limits;
    logic wdog_expired;

    // ==========================================================
    // Decode
    wire sel_12 = (ptr_in == PTR_LINREG_12);
    wire sel_34 = (ptr_in == PTR_LINREG_34);
    wire sel_su = (ptr_in == PTR_STEP_UP);
    wire sel_ca = (ptr_in == PTR_CHG_MAIN);
    wire sel_cb = (ptr_in == PTR_CHG_LIMITS);
    wire sel_any = sel_12 | sel_34 | sel_su | sel_ca | sel_cb;
    wire access = wr_in | rd_in;
    wire chg_touch = access & (sel_ca | sel_cb);
    wire [7:0] next_rdata = sel_12 ? linreg_12_voltage :
                            sel_34 ? linreg_34_voltage :
                            sel_su ? (step_up_voltage & STEP_UP_MASK) :
                            sel_ca ? charger_setup_main :
                            sel_cb ? charger_setup_limits : 8'h00;

    // ==========================================================
    // Registers
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            linreg_12_voltage <= RST_LINREG_12;
            linreg_34_voltage <= RST_LINREG_34;
            step_up_voltage <= RST_STEP_UP;
            charger_setup_main <= RST_CHG_MAIN;
            charger_setup_limits <= RST_CHG_LIMITS;
        end else if (clk_en_in && wr_in) begin
            if (sel_12) linreg_12_voltage <= wdata_in;
            if (sel_34) linreg_34_voltage <= wdata_in;
            if (sel_su) step_up_voltage <= wdata_in & STEP_UP_MASK;
            if (sel_ca) charger_setup_main <= wdata_in;
            if (sel_cb) charger_setup_limits <= wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            rdata_out <= 8'h00;
            hit_out <= 1'b0;
        end else if (clk_en_in) begin
            hit_out <= access & sel_any;
            if (rd_in) rdata_out <= next_rdata;
        end
    end

    // Expiry holds until rst_n_in is asserted; this block has no other clear
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            watchdog_expiry_flag_out <= 1'b0;
        end else if (clk_en_in && wdog_expired) begin
            watchdog_expiry_flag_out <= 1'b1;
        end
    end

    charge_watchdog #(.EXPIRY_CYCLES(EXPIRY_CYCLES)) u_wdog (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .run_in(charge_watchdog_on_in),
        .restart_in(chg_touch),
        .expired_out(wdog_expired)
    );

    // ==========================================================
    // Field outputs
    assign vsel_out.linreg1_vsel = linreg_12_voltage[3:0];
    assign vsel_out.linreg2_vsel = linreg_12_voltage[7:4];
    assign vsel_out.linreg3_vsel = linreg_34_voltage[3:0];
    assign vsel_out.linreg4_vsel = linreg_34_voltage[7:4];
    assign vsel_out.stepup_vsel = step_up_voltage[3:0];
    assign chg_main_out = chg_main_t'(charger_setup_main);
    assign chg_limits_out = chg_limits_t'(charger_setup_limits);

    // ==========================================================
    // Checks
    a_stepup_reserved_zero: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) (clk_en_in && rd_in && sel_su)
        |=> rdata_out[7:4] == 4'h0)
        else $error("Step-up reserved bits read nonzero");
    a_main_write_stored: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) (clk_en_in && wr_in && sel_ca)
        |=> charger_setup_main == $past(wdata_in))
        else $error("Charger main write lost");
    a_limits_write_stored: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) (clk_en_in && wr_in && sel_cb)
        |=> charger_setup_limits == $past(wdata_in))
        else $error("Charger limits write lost");
    a_reset_34_value: assert property (@(posedge sys_clk_in)
        !rst_n_in |=> linreg_34_voltage == 8'hBB)
        else $error("Regulator 3/4 reset value wrong");
    a_reset_chg_values: assert property (@(posedge sys_clk_in)
        !rst_n_in |=> charger_setup_main == 8'h1F &&
        charger_setup_limits == 8'h20)
        else $error("Charger reset values wrong");
    a_reset_stepup_value: assert property (@(posedge sys_clk_in)
        !rst_n_in |=> step_up_voltage == 8'h0F)
        else $error("Step-up reset value wrong");
    a_read_34_value: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) (clk_en_in && rd_in && sel_34 && !wr_in)
        |=> rdata_out == linreg_34_voltage)
        else $error("Pointer 07 read wrong data");
    a_expiry_sticky: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) watchdog_expiry_flag_out
        |=> watchdog_expiry_flag_out)
        else $error("Expiry flag dropped");
    a_field_map: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        vsel_out.linreg2_vsel == linreg_12_voltage[7:4] &&
        chg_main_out.charger_on == charger_setup_main[0])
        else $error("Field mapping wrong");

    // ==========================================================
    // Checks on masking, writes, reads, hit, unmapped pointers, freeze, watchdog and field resets
    a_stepup_write_masked: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) (clk_en_in && wr_in && sel_su)
        |=> step_up_voltage == {4'h0, $past(wdata_in[3:0])})
        else $error("Step-up write not masked");
    a_reg34_write_stored: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) (clk_en_in && wr_in && sel_34)
        |=> linreg_34_voltage == $past(wdata_in))
        else $error("Regulator 3/4 write lost");
    a_reg12_write_stored: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) (clk_en_in && wr_in && sel_12)
        |=> linreg_12_voltage == $past(wdata_in))
        else $error("Regulator 1/2 write lost");
    a_unmapped_write_ignored: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) (clk_en_in && wr_in && !sel_any)
        |=> $stable(linreg_12_voltage) && $stable(linreg_34_voltage) &&
        $stable(step_up_voltage) && $stable(charger_setup_main) &&
        $stable(charger_setup_limits))
        else $error("Unmapped write changed a register");
    a_unmapped_read_zero: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) (clk_en_in && rd_in && !sel_any)
        |=> rdata_out == 8'h00 && !hit_out)
        else $error("Unmapped read not zero");
    a_hit_on_mapped: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) (clk_en_in && (wr_in || rd_in) && sel_any)
        |=> hit_out)
        else $error("Mapped access without hit");
    a_hit_one_cycle: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) (clk_en_in && !wr_in && !rd_in)
        |=> !hit_out)
        else $error("Hit without access");
    a_rdata_holds: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) !(clk_en_in && rd_in)
        |=> $stable(rdata_out))
        else $error("Read data changed without a read");
    a_freeze_holds: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) !clk_en_in
        |=> $stable(linreg_34_voltage) && $stable(charger_setup_main) &&
        $stable(rdata_out) && $stable(hit_out) &&
        $stable(watchdog_expiry_flag_out))
        else $error("State moved while clock enable low");
    a_read_main_value: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) (clk_en_in && rd_in && sel_ca && !wr_in)
        |=> rdata_out == charger_setup_main)
        else $error("Charger main read wrong data");
    a_read_limits_value: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) (clk_en_in && rd_in && sel_cb && !wr_in)
        |=> rdata_out == charger_setup_limits)
        else $error("Charger limits read wrong data");
    a_read_stepup_value: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) (clk_en_in && rd_in && sel_su && !wr_in)
        |=> rdata_out == step_up_voltage)
        else $error("Step-up read wrong data");
    a_flag_sets_on_expiry: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) (clk_en_in && wdog_expired)
        |=> watchdog_expiry_flag_out)
        else $error("Expiry did not set the flag");
    a_flag_needs_expiry: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) $rose(watchdog_expiry_flag_out)
        |-> $past(wdog_expired))
        else $error("Flag set without expiry");
    a_restart_on_access: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) (clk_en_in && (wr_in || rd_in) &&
        (ptr_in == PTR_CHG_MAIN || ptr_in == PTR_CHG_LIMITS))
        |=> !wdog_expired)
        else $error("Charger access did not restart watchdog");
    a_watchdog_off_quiet: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) (clk_en_in && !charge_watchdog_on_in)
        |=> !wdog_expired)
        else $error("Watchdog expired while disabled");
    a_reset_charger_on: assert property (@(posedge sys_clk_in)
        !rst_n_in |=> chg_main_out.charger_on == 1'h1)
        else $error("Charger enable reset value wrong");
    a_reset_topoff_thr: assert property (@(posedge sys_clk_in)
        !rst_n_in |=> chg_main_out.topoff_thr == 2'h3)
        else $error("Top-off threshold reset value wrong");
    a_reset_restart_thr: assert property (@(posedge sys_clk_in)
        !rst_n_in |=> chg_main_out.restart_thr == 2'h3)
        else $error("Restart threshold reset value wrong");
    a_reset_fast_current: assert property (@(posedge sys_clk_in)
        !rst_n_in |=> chg_main_out.fast_current == 3'h0)
        else $error("Fast-charge current reset value wrong");
    a_reset_bulk_timer: assert property (@(posedge sys_clk_in)
        !rst_n_in |=> chg_limits_out.bulk_timer_sel == 2'h0)
        else $error("Bulk timer reset value wrong");
    a_reset_thermal: assert property (@(posedge sys_clk_in)
        !rst_n_in |=> chg_limits_out.thermal_limit == 2'h2)
        else $error("Thermal limit reset value wrong");
    a_reset_finish_timer: assert property (@(posedge sys_clk_in)
        !rst_n_in |=> chg_limits_out.finish_timer_sel == 2'h0)
        else $error("Finish timer reset value wrong");

    c_write_main: cover property (@(posedge sys_clk_in)
        wr_in && sel_ca);
    c_read_stepup: cover property (@(posedge sys_clk_in)
        rd_in && sel_su);
    c_expiry: cover property (@(posedge sys_clk_in)
        wdog_expired);
    c_frozen_write: cover property (@(posedge sys_clk_in)
        !clk_en_in && wr_in);
    c_unmapped_read: cover property (@(posedge sys_clk_in)
        rd_in && !sel_any);
endmodule : supply_charger_regs

// ===== hdl/chg_cfg_pkg.sv
// Constants, field layouts and carriers for the supply/charger config bank.
// Assumes a single 40 MHz clock and a byte-wide register port.
// Operation
// - Pointers 06..0A decode to the five registers.
// - Bits 7:4 at 06 select second regulator.
// - Bits 3:0 at 07 third regulator, default 1011.
// - Bits 7:4 at 07 fourth regulator, default 1011.
// - Step-up code bits 3:0, resets 0x0F.
// - Charger enable bit 0, default on.
// - Top-off threshold bits 2:1, default 11.
// - Restart threshold bits 4:3, default 11.
// - Fast-charge current bits 7:5, default 000.
// - Any charger register access restarts watchdog.
// - Bulk timer bits 3:2 of second charger register.
// - Thermal limit bits 5:4, default 10.
// - Finish timer bits 7:6, default 00.
// - Bits 3:0 at 06 select first regulator.
// - Watchdog runs only while enable bit set.
// - Watchdog expiry sets event bit 2; here it sets watchdog_expiry_flag_out, and EVT_WDOG_BIT is unused.
package chg_cfg_pkg;
    // ==========================================================
    // Register pointers
    localparam logic [7:0] PTR_LINREG_12 = 8'h06;
    localparam logic [7:0] PTR_LINREG_34 = 8'h07;
    localparam logic [7:0] PTR_STEP_UP = 8'h08;
    localparam logic [7:0] PTR_CHG_MAIN = 8'h09;
    localparam logic [7:0] PTR_CHG_LIMITS = 8'h0A;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_LINREG_12 = 8'h1C;
    localparam logic [7:0] RST_LINREG_34 = 8'hBB;
    localparam logic [7:0] RST_STEP_UP = 8'h0F;
    localparam logic [7:0] RST_CHG_MAIN = 8'h1F;
    localparam logic [7:0] RST_CHG_LIMITS = 8'h20;
    localparam logic [7:0] STEP_UP_MASK = 8'h0F;
    // ==========================================================
    // Watchdog expiry in system clocks; plain default, set per product
    localparam int WDOG_CYCLES = 32'h0100_0000;
    localparam int EVT_WDOG_BIT = 2;

    typedef struct packed {
        logic [2:0] fast_current;
        logic [1:0] restart_thr;
        logic [1:0] topoff_thr;
        logic charger_on;
    } chg_main_t;

    typedef struct packed {
        logic [1:0] finish_timer_sel;
        logic [1:0] thermal_limit;
        logic [1:0] bulk_timer_sel;
        logic [1:0] charge_voltage;
    } chg_limits_t;

    typedef struct packed {
        logic [3:0] linreg1_vsel;
        logic [3:0] linreg2_vsel;
        logic [3:0] linreg3_vsel;
        logic [3:0] linreg4_vsel;
        logic [3:0] stepup_vsel;
    } vsel_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] ptr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage : chg_cfg_pkg

// ===== hdl/charge_watchdog.sv
// Charge watchdog counter with restart and expiry pulse.
// Assumes restart pulses come from the register bank on the same clock.
`timescale 1ns/1ps
module charge_watchdog import chg_cfg_pkg::*; #(
    parameter int EXPIRY_CYCLES = WDOG_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic run_in,
    input wire logic restart_in,
    output logic expired_out
);
    logic [31:0] count;
    wire at_end = (count == 32'(EXPIRY_CYCLES - 1));
    // Clearing the count while disabled keeps a stale count from firing at enable
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            count <= 32'h0;
            expired_out <= 1'b0;
        end else if (clk_en_in) begin
            expired_out <= run_in && !restart_in && at_end;
            if (!run_in || restart_in || at_end) begin
                count <= 32'h0;
            end else begin
                count <= count + 32'h1;
            end
        end
    end

    a_expiry_needs_run: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) (expired_out && $past(clk_en_in))
        |-> $past(run_in))
        else $error("Watchdog expired while disabled");
    a_restart_blocks: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) (clk_en_in && restart_in) |=> !expired_out)
        else $error("Watchdog expired right after restart");
endmodule : charge_watchdog

// ===== testbench/host_model.sv
// Host-side model of the serial front end: single-cycle strobes.
// Assumes a free-running sys clock; one access every two cycles.
`timescale 1ns/1ps
module host_model (
    input wire logic clk_in,
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] ptr_out,
    output logic [7:0] wdata_out
);
    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        ptr_out = 8'hFF;
        wdata_out = 8'h00;
    end
    // ==========================================================
    // Bus access, also used to feed the watchdog
    task automatic access(input logic w, input logic [7:0] p,
                          input logic [7:0] d);
        @(posedge clk_in);
        #1;
        wr_out = w;
        rd_out = ~w;
        ptr_out = p;
        wdata_out = d;
        @(posedge clk_in);
        #1;
        // Stale lines flip so an old value never looks valid
        wr_out = 1'b0;
        rd_out = 1'b0;
        ptr_out = ~p;
        wdata_out = ~d;
    endtask : access
endmodule : host_model

// ===== testbench/pmic_supply_charger_config_regs_tb_top.sv
// Self-checking bench for the supply/charger register bank.
// Assumes host_model drives strobes; watchdog shortened to 16.
`timescale 1ns/1ps
module pmic_supply_charger_config_regs_tb_top import chg_cfg_pkg::*;;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic clk_en_in = 1'b1;
    logic wdog_on = 1'b0;
    logic wr, rd, hit, flag;
    logic [7:0] ptr, wdata, rdata;
    vsel_t vsel;
    chg_main_t cmain;
    chg_limits_t climits;
    logic [7:0] regs [6:10];
    logic [8:0] notes [$];
    logic pend = 1'b0;
    logic [31:0] seed = 32'hE5C51B29;
    int n_errors = 0;
    int comparisons = 0;
    int n;
    localparam int WD_TEST = 16;
    always #12.5 sys_clk_in = ~sys_clk_in;
    supply_charger_regs #(.EXPIRY_CYCLES(WD_TEST)) supply_charger_regs_inst (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in), .wr_in(wr), .rd_in(rd), .ptr_in(ptr),
        .wdata_in(wdata), .charge_watchdog_on_in(wdog_on),
        .rdata_out(rdata), .hit_out(hit), .vsel_out(vsel),
        .chg_main_out(cmain), .chg_limits_out(climits),
        .watchdog_expiry_flag_out(flag));
    host_model host_model_inst (.clk_in(sys_clk_in), .wr_out(wr),
        .rd_out(rd), .ptr_out(ptr), .wdata_out(wdata));
    // ==========================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input string what, input logic [19:0] exp,
                         input logic [19:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk_in);
        #1;
    endtask : tick
    task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
        host_model_inst.access(1'b1, p, d);
        if (p == 8'h08) regs[p] = {4'h0, d[3:0]};
        else if (p >= 8'h06 && p <= 8'h0A) regs[p] = d;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] p);
        logic mapped;
        mapped = (p >= 8'h06 && p <= 8'h0A);
        notes.push_back({mapped, mapped ? regs[p] : 8'h00});
        host_model_inst.access(1'b0, p, 8'h00);
    endtask : rd_reg
    task automatic outputs_ok;
        check("vsel", {regs[6][3:0], regs[6][7:4], regs[7][3:0],
              regs[7][7:4], regs[8][3:0]}, vsel);
        check("chg main", {12'h0, regs[9]}, {12'h0, cmain});
        check("chg limits", {12'h0, regs[10]}, {12'h0, climits});
    endtask : outputs_ok
    task automatic final_report;
        $display("Comparisons %0d, errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    // ==========================================================
    // Read monitor: answer lands one edge after the strobe is taken
    always @(posedge sys_clk_in) begin
        if (pend) begin
            check("read", {11'h0, notes.pop_front()}, {11'h0, hit, rdata});
        end
        pend = rd;
    end
    // ==========================================================
    // Main sequence
    initial begin
        regs = '{8'h1C, 8'hBB, 8'h0F, 8'h1F, 8'h20};
        tick(20);
        rst_n_in = 1'b1;
        outputs_ok();
        for (int p = 5; p <= 11; p++) rd_reg(8'(p));
        // Random data on every pointer, the unmapped one included
        for (int i = 0; i < 4; i++) begin
            for (int p = 6; p <= 11; p++) begin
                seed = lfsr(seed);
                wr_reg(8'(p), seed[7:0]);
                outputs_ok();
                rd_reg(8'(p));
            end
        end
        // Watchdog held off: no expiry however long
        tick(40);
        check("flag idle", 20'h0, {19'h0, flag});
        wdog_on = 1'b1;
        for (int i = 0; i < 6; i++) begin
            tick(8);
            if (i < 4) rd_reg(i[0] ? PTR_CHG_LIMITS : PTR_CHG_MAIN);
            else if (i[0]) wr_reg(PTR_CHG_LIMITS, regs[10]);
            else wr_reg(PTR_CHG_MAIN, regs[9]);
        end
        check("flag fed", 20'h0, {19'h0, flag});
        // Frozen enable: the write is dropped and the count stalls
        clk_en_in = 1'b0;
        host_model_inst.access(1'b1, PTR_LINREG_34, ~regs[7]);
        tick(8);
        clk_en_in = 1'b1;
        outputs_ok();
        check("flag frozen", 20'h0, {19'h0, flag});
        n = 0;
        while (flag !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        check("expiry", 20'h1, {19'h0, n == WD_TEST + 1});
        tick(3);
        // Mid-run reset clears the sticky flag and restores defaults
        rst_n_in = 1'b0;
        tick(2);
        rst_n_in = 1'b1;
        regs = '{8'h1C, 8'hBB, 8'h0F, 8'h1F, 8'h20};
        outputs_ok();
        check("reset flag", 20'h0, {19'h0, flag});
        check("reset read", 20'h0, {11'h0, hit, rdata});
        rd_reg(PTR_CHG_LIMITS);
        tick(3);
        final_report();
    end
endmodule : pmic_supply_charger_config_regs_tb_top
